// >>> inc/apt_pkg.sv
`default_nettype none
package apt_pkg;

  // ==========================================================
  // widths
  localparam int INSTR_W = 10;
  localparam int NIBBLE_W = 4;
  localparam int PRESCALE_W = 8;

  // ==========================================================
  // instruction codes
  localparam logic [INSTR_W-1:0] OP_XFER_ACC_TO_TIMER_CTL = 10'h2aa;
  localparam logic [INSTR_W-1:0] OP_XFER_ACC_B_TO_PRESCALER = 10'h235;
  localparam logic [INSTR_W-1:0] OP_XFER_ACC_TO_PULLUP_ZERO = 10'h22d;
  // leading nine bits fixed, last bit assumed zero
  localparam logic [INSTR_W-1:0] OP_XFER_ACC_TO_PULLUP_ONE = 10'h22c;

  // ==========================================================
  // field positions
  localparam int ACC_BIT0_POS = 0;
  localparam int PRESCALE_HI_LSB = 4;
  localparam int PRESCALE_LO_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic RST_TIMER_CTL_BIT0 = 1'h0;
  localparam logic [PRESCALE_W-1:0] RST_PRESCALER = 8'h00;
  localparam logic [NIBBLE_W-1:0] RST_PULLUP = 4'h0;
  localparam logic RST_STATUS_BIT = 1'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
  } apt_instr_t;

  typedef struct packed {
    logic [NIBBLE_W-1:0] acc;
    logic [NIBBLE_W-1:0] regB;
  } apt_src_t;

  typedef enum logic [2:0] {
    APT_OP_NONE,
    APT_OP_TIMER_CTL,
    APT_OP_PRESCALER,
    APT_OP_PULLUP_ZERO,
    APT_OP_PULLUP_ONE
  } apt_op_t;

endpackage

`default_nettype wire

// >>> rtl/apt_periph_xfer.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - 2AA copies acc bit 0 to timer control
// - 235 decodes as one-cycle prescaler load
// - B high nibble, acc low, both prescaler registers
// - 22D copies accumulator into pull-up zero
// - pull-up-one code copies accumulator into pull-up one
module apt_periph_xfer #(
  parameter logic [apt_pkg::INSTR_W-1:0] PULLUP_ONE_CODE = apt_pkg::OP_XFER_ACC_TO_PULLUP_ONE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire apt_pkg::apt_instr_t instrIn,
  input wire apt_pkg::apt_src_t srcIn,
  output logic timerCtlBit0,
  output logic [apt_pkg::PRESCALE_W-1:0] prescalerCounterLoad,
  output logic prescalerCounterLoadStrobe,
  output logic [apt_pkg::PRESCALE_W-1:0] prescalerReloadReg,
  output logic [apt_pkg::NIBBLE_W-1:0] pullupCtlZero,
  output logic [apt_pkg::NIBBLE_W-1:0] pullupCtlOne,
  output logic instrRecognised,
  output logic skipRequest,
  output logic carryWriteEnable
);

  // ==========================================================
  // decode
  function automatic logic isCode(
    input logic valid,
    input logic [apt_pkg::INSTR_W-1:0] word,
    input logic [apt_pkg::INSTR_W-1:0] code
  );
    return valid && (word == code);
  endfunction

  function automatic apt_pkg::apt_op_t decodeOp(
    input logic valid,
    input logic [apt_pkg::INSTR_W-1:0] word,
    input logic [apt_pkg::INSTR_W-1:0] pullupOneCode
  );
    apt_pkg::apt_op_t op;
    op = apt_pkg::APT_OP_NONE;
    if (isCode(valid, word, apt_pkg::OP_XFER_ACC_TO_TIMER_CTL)) begin
      op = apt_pkg::APT_OP_TIMER_CTL;
    end else if (isCode(valid, word, apt_pkg::OP_XFER_ACC_B_TO_PRESCALER)) begin
      op = apt_pkg::APT_OP_PRESCALER;
    end else if (isCode(valid, word, apt_pkg::OP_XFER_ACC_TO_PULLUP_ZERO)) begin
      op = apt_pkg::APT_OP_PULLUP_ZERO;
    end else if (isCode(valid, word, pullupOneCode)) begin
      op = apt_pkg::APT_OP_PULLUP_ONE;
    end
    return op;
  endfunction

  // ==========================================================
  // selected operation
  wire apt_pkg::apt_op_t curOp;
  wire logic hitTimerCtl;
  wire logic hitPrescaler;
  wire logic hitPullupZero;
  wire logic hitPullupOne;
  wire logic hitAny;

  assign curOp = decodeOp(instrIn.valid, instrIn.word, PULLUP_ONE_CODE);
  assign hitTimerCtl = (curOp == apt_pkg::APT_OP_TIMER_CTL);
  assign hitPrescaler = (curOp == apt_pkg::APT_OP_PRESCALER);
  assign hitPullupZero = (curOp == apt_pkg::APT_OP_PULLUP_ZERO);
  assign hitPullupOne = (curOp == apt_pkg::APT_OP_PULLUP_ONE);
  assign hitAny = (curOp != apt_pkg::APT_OP_NONE);

  // ==========================================================
  // data registers
  logic timerCtlBit0_reg;
  logic [apt_pkg::PRESCALE_W-1:0] prescalerCounterLoad_reg;
  logic [apt_pkg::PRESCALE_W-1:0] prescalerReloadReg_reg;
  logic [apt_pkg::NIBBLE_W-1:0] pullupCtlZero_reg;
  logic [apt_pkg::NIBBLE_W-1:0] pullupCtlOne_reg;

  // ==========================================================
  // status registers
  logic prescalerCounterLoadStrobe_reg;
  logic instrRecognised_reg;
  logic skipRequest_reg;
  logic carryWriteEnable_reg;

  // ==========================================================
  // data next values
  wire logic [apt_pkg::PRESCALE_W-1:0] prescaleValue;
  wire logic timerCtlBit0_next;
  wire logic [apt_pkg::PRESCALE_W-1:0] prescalerCounterLoad_next;
  wire logic [apt_pkg::PRESCALE_W-1:0] prescalerReloadReg_next;
  wire logic [apt_pkg::NIBBLE_W-1:0] pullupCtlZero_next;
  wire logic [apt_pkg::NIBBLE_W-1:0] pullupCtlOne_next;

  assign prescaleValue[apt_pkg::PRESCALE_HI_LSB +: apt_pkg::NIBBLE_W] = srcIn.regB;
  assign prescaleValue[apt_pkg::PRESCALE_LO_LSB +: apt_pkg::NIBBLE_W] = srcIn.acc;
  // only bit 0 moves; other timer control bits live elsewhere
  assign timerCtlBit0_next =
    hitTimerCtl ? srcIn.acc[apt_pkg::ACC_BIT0_POS] : timerCtlBit0_reg;
  assign prescalerCounterLoad_next =
    hitPrescaler ? prescaleValue : prescalerCounterLoad_reg;
  assign prescalerReloadReg_next =
    hitPrescaler ? prescaleValue : prescalerReloadReg_reg;
  assign pullupCtlZero_next =
    hitPullupZero ? srcIn.acc : pullupCtlZero_reg;
  assign pullupCtlOne_next =
    hitPullupOne ? srcIn.acc : pullupCtlOne_reg;

  // ==========================================================
  // status next values
  wire logic prescalerCounterLoadStrobe_next;
  wire logic instrRecognised_next;
  wire logic skipRequest_next;
  wire logic carryWriteEnable_next;

  assign prescalerCounterLoadStrobe_next = hitPrescaler;
  assign instrRecognised_next = hitAny;
  // none of these transfers skip or touch carry
  assign skipRequest_next = 1'h0;
  assign carryWriteEnable_next = 1'h0;

  // ==========================================================
  // timer control bit 0
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timerCtlBit0_reg <= apt_pkg::RST_TIMER_CTL_BIT0;
    end else begin
      timerCtlBit0_reg <= timerCtlBit0_next;
    end
  end

  // ==========================================================
  // prescaler counter load value
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prescalerCounterLoad_reg <= apt_pkg::RST_PRESCALER;
    end else begin
      prescalerCounterLoad_reg <= prescalerCounterLoad_next;
    end
  end

  // ==========================================================
  // prescaler counter load strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prescalerCounterLoadStrobe_reg <= apt_pkg::RST_STATUS_BIT;
    end else begin
      prescalerCounterLoadStrobe_reg <= prescalerCounterLoadStrobe_next;
    end
  end

  // ==========================================================
  // prescaler reload register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prescalerReloadReg_reg <= apt_pkg::RST_PRESCALER;
    end else begin
      prescalerReloadReg_reg <= prescalerReloadReg_next;
    end
  end

  // ==========================================================
  // pull-up control zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pullupCtlZero_reg <= apt_pkg::RST_PULLUP;
    end else begin
      pullupCtlZero_reg <= pullupCtlZero_next;
    end
  end

  // ==========================================================
  // pull-up control one
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pullupCtlOne_reg <= apt_pkg::RST_PULLUP;
    end else begin
      pullupCtlOne_reg <= pullupCtlOne_next;
    end
  end

  // ==========================================================
  // recognised pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      instrRecognised_reg <= apt_pkg::RST_STATUS_BIT;
    end else begin
      instrRecognised_reg <= instrRecognised_next;
    end
  end

  // ==========================================================
  // skip request
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      skipRequest_reg <= apt_pkg::RST_STATUS_BIT;
    end else begin
      skipRequest_reg <= skipRequest_next;
    end
  end

  // ==========================================================
  // carry write enable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      carryWriteEnable_reg <= apt_pkg::RST_STATUS_BIT;
    end else begin
      carryWriteEnable_reg <= carryWriteEnable_next;
    end
  end

  // ==========================================================
  // data outputs
  assign timerCtlBit0 = timerCtlBit0_reg;
  assign prescalerCounterLoad = prescalerCounterLoad_reg;
  assign prescalerReloadReg = prescalerReloadReg_reg;
  assign pullupCtlZero = pullupCtlZero_reg;
  assign pullupCtlOne = pullupCtlOne_reg;

  // ==========================================================
  // status outputs
  assign prescalerCounterLoadStrobe = prescalerCounterLoadStrobe_reg;
  assign instrRecognised = instrRecognised_reg;
  assign skipRequest = skipRequest_reg;
  assign carryWriteEnable = carryWriteEnable_reg;

endmodule

`default_nettype wire

// >>> testbench/apt_periph_xfer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module apt_periph_xfer_asserts #(
  parameter logic [apt_pkg::INSTR_W-1:0] PULLUP_ONE_CODE = apt_pkg::OP_XFER_ACC_TO_PULLUP_ONE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire apt_pkg::apt_instr_t instrIn,
  input wire apt_pkg::apt_src_t srcIn,
  input wire logic timerCtlBit0,
  input wire logic [apt_pkg::PRESCALE_W-1:0] prescalerCounterLoad,
  input wire logic prescalerCounterLoadStrobe,
  input wire logic [apt_pkg::PRESCALE_W-1:0] prescalerReloadReg,
  input wire logic [apt_pkg::NIBBLE_W-1:0] pullupCtlZero,
  input wire logic [apt_pkg::NIBBLE_W-1:0] pullupCtlOne,
  input wire logic instrRecognised,
  input wire logic skipRequest,
  input wire logic carryWriteEnable
);
  wire logic takeTimer =
    instrIn.valid && instrIn.word == apt_pkg::OP_XFER_ACC_TO_TIMER_CTL;
  wire logic takePrescaler =
    instrIn.valid && instrIn.word == apt_pkg::OP_XFER_ACC_B_TO_PRESCALER;
  wire logic takePullupZero =
    instrIn.valid && instrIn.word == apt_pkg::OP_XFER_ACC_TO_PULLUP_ZERO;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take(w);
    instrIn.valid && instrIn.word == w;
  endsequence
  a_timer_bit: assert property (s_take(apt_pkg::OP_XFER_ACC_TO_TIMER_CTL)
    |=> timerCtlBit0 == $past(srcIn.acc[0])) else $error("timer bit");
  a_pre_pulse: assert property (s_take(apt_pkg::OP_XFER_ACC_B_TO_PRESCALER)
    |=> prescalerCounterLoadStrobe && instrRecognised) else $error("prescaler pulse");
  a_pre_value: assert property (s_take(apt_pkg::OP_XFER_ACC_B_TO_PRESCALER)
    |=> {prescalerReloadReg, prescalerCounterLoad} == {2{$past({srcIn.regB, srcIn.acc})}})
    else $error("prescaler value");
  a_pullup_zero: assert property (s_take(apt_pkg::OP_XFER_ACC_TO_PULLUP_ZERO)
    |=> pullupCtlZero == $past(srcIn.acc)) else $error("pull-up zero");
  a_pullup_one: assert property (s_take(PULLUP_ONE_CODE)
    |=> pullupCtlOne == $past(srcIn.acc)) else $error("pull-up one");
  a_idle_hold: assert property (!instrIn.valid
    |=> !instrRecognised && $stable(pullupCtlOne)) else $error("idle change");
  a_pre_single: assert property (!takePrescaler
    |=> !prescalerCounterLoadStrobe) else $error("prescaler pulse without load");
  a_timer_hold: assert property (!takeTimer
    |=> $stable(timerCtlBit0)) else $error("timer bit changed");
  a_zero_hold: assert property (!takePullupZero
    |=> $stable(pullupCtlZero)) else $error("pull-up zero changed");
  a_no_skip: assert property (!skipRequest)
    else $error("skip requested");
  a_no_carry: assert property (!carryWriteEnable)
    else $error("carry written");
endmodule
bind apt_periph_xfer apt_periph_xfer_asserts #(.PULLUP_ONE_CODE(PULLUP_ONE_CODE)) u_chk (.*);
`default_nettype wire

// >>> testbench/apt_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module apt_core_model (
  input wire logic clk,
  output var apt_pkg::apt_instr_t instr,
  output var apt_pkg::apt_src_t src
);
  initial instr = '0;
  initial src = '0;
  // idle cycles show the inverse, not the last value
  task automatic issue(input logic v, input logic [9:0] w, input logic [7:0] s);
    @(posedge clk);
    instr <= {v, v ? w : ~instr.word};
    src <= v ? s : ~src;
  endtask
endmodule
`default_nettype wire

// >>> testbench/apt_periph_xfer_test.sv
`timescale 1ns/1ns
`default_nettype none
module apt_periph_xfer_test;
  logic ref_clk = 0, reset_n = 0, v, rec, skp, cwe;
  apt_pkg::apt_instr_t instrIn;
  apt_pkg::apt_src_t srcIn;
  logic [25:0] seen, exp = '0, notes [$];
  logic [9:0] w, codes [4] = '{apt_pkg::OP_XFER_ACC_TO_TIMER_CTL,
    apt_pkg::OP_XFER_ACC_B_TO_PRESCALER, apt_pkg::OP_XFER_ACC_TO_PULLUP_ZERO,
    apt_pkg::OP_XFER_ACC_TO_PULLUP_ONE};
  logic [3:0] a, b;
  int failCount = 0, comparisons = 0, cycles = 0;
  apt_core_model i_core (.clk(ref_clk), .instr(instrIn), .src(srcIn));
  apt_periph_xfer i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .instrIn(instrIn),
    .srcIn(srcIn), .prescalerCounterLoadStrobe(seen[25]), .timerCtlBit0(seen[24]),
    .prescalerReloadReg(seen[23:16]), .prescalerCounterLoad(seen[15:8]),
    .pullupCtlZero(seen[7:4]), .pullupCtlOne(seen[3:0]), .instrRecognised(rec),
    .skipRequest(skp), .carryWriteEnable(cwe));
  always #2 ref_clk = ~ref_clk;
  task automatic check(input string nm, input logic [25:0] got, want);
    comparisons++;
    if (got !== want) begin
      failCount++;
      $display("BAD %s exp %h seen %h", nm, want, got);
    end
  endtask
  task automatic reportAndStop();
    $display("comparisons %0d failCount %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    #1;
    check("skip carry", {skp, cwe}, 2'b00);
    if (rec === 1'b1) begin
      if (notes.size() == 0) check("extra result", 1, 0);
      else check("outputs", seen, notes.pop_front());
    end else begin
      check("idle strobe", seen[25], 0);
    end
  end
  always @(posedge ref_clk) if (++cycles == 3000) begin
    failCount++;
    reportAndStop();
  end
  initial begin
    void'($urandom(32'h72dc));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1;
    repeat (600) begin
      v = $urandom_range(3) != 0;
      w = ($urandom_range(7) == 0) ? 10'($urandom) : codes[$urandom_range(3)];
      a = 4'($urandom);
      b = 4'($urandom);
      i_core.issue(v, w, {a, b});
      exp[25] = 0;
      if (v) case (w)
        apt_pkg::OP_XFER_ACC_TO_TIMER_CTL: exp[24] = a[0];
        apt_pkg::OP_XFER_ACC_B_TO_PRESCALER: begin
          exp[25] = 1;
          exp[23:8] = {b, a, b, a};
        end
        apt_pkg::OP_XFER_ACC_TO_PULLUP_ZERO: exp[7:4] = a;
        apt_pkg::OP_XFER_ACC_TO_PULLUP_ONE: exp[3:0] = a;
        default: v = 0;
      endcase
      if (v) notes.push_back(exp);
    end
    i_core.issue(0, 0, 0);
    repeat (2) @(posedge ref_clk);
    check("missing results", 26'(notes.size()), 0);
    reportAndStop();
  end
endmodule
`default_nettype wire
